//--- pfc_pkg.sv
/*
 * Constants for the port and shared-pin control block: register offsets,
 * reset values, field positions and the noise filter length.
 * Assumes a single 20 MHz system clock and a byte-wide register port.
 */
package pfc_pkg;
    // ****************************************************************
    // Bus geometry
    // ****************************************************************
    localparam int AW = 5;
    localparam int DW = 8;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [4:0] R_PA_DATA  = 5'h00;
    localparam logic [4:0] R_PA_DIR   = 5'h01;
    localparam logic [4:0] R_PA_PU    = 5'h02;
    localparam logic [4:0] R_PC_DATA  = 5'h03;
    localparam logic [4:0] R_PC_DIR   = 5'h04;
    localparam logic [4:0] R_PC_PU    = 5'h05;
    localparam logic [4:0] R_OD_DATA  = 5'h06;
    localparam logic [4:0] R_PK_DATA  = 5'h07;
    localparam logic [4:0] R_PK_DIR   = 5'h08;
    localparam logic [4:0] R_PK_PU    = 5'h09;
    localparam logic [4:0] R_SEG_EN   = 5'h0a;
    localparam logic [4:0] R_SEG_DATA = 5'h0b;
    localparam logic [4:0] R_SEG_DIR  = 5'h0c;
    localparam logic [4:0] R_SEG_PU   = 5'h0d;
    localparam logic [4:0] R_CFG      = 5'h0e;
    localparam logic [4:0] R_STATUS   = 5'h0f;
    localparam logic [4:0] R_MASK     = 5'h10;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CFG_SEL_FALL  = 0;
    localparam int CFG_NF_EN     = 1;
    localparam int CFG_EXP_CLK   = 2;
    localparam int CFG_SPLIT_RES = 3;
    localparam int ST_BOTH_EDGE  = 0;
    localparam int ST_SEL_EDGE   = 1;
    localparam int ST_KEY        = 2;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [3:0] OD_RESET  = 4'hf;
    localparam logic [3:0] DIR_RESET = 4'h0;
    localparam logic [3:0] CFG_RESET = 4'h0;

    // ****************************************************************
    // Noise filter timing
    // ****************************************************************
    localparam int CLK_MHZ   = 20;
    localparam int NF_MIN_NS = 200;
    localparam int NF_CYCLES_INT = (NF_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] NF_CYCLES = 4'(NF_CYCLES_INT);
endpackage

//--- pfc_port_ctrl.sv
/*
 * Port and shared-pin control: input port, programmable ports,
 * open-drain port, key port, segment pins as ports, edge interrupts,
 * key-return flag, PROM data/mode pins, expansion clocks, bias output.
 * Assumes synchronous pin inputs and one clock; pin wires are resolved
 * outside from the out/oe pairs.
 */
// Local design decisions: the register offsets and the plain strobed port.
// Operation
// - A four-bit input port whose bit 0 is the both-edge interrupt and bits 1-3 are two-way.
// - The three two-way bits of the input port each take a software pull-up.
// - Software chooses whether a noise filter sits in the select-edge interrupt path.
// - The programmable ports set each bit as input or output on its own.
// - Programmable port pull-ups take effect only when the whole nibble is one unit.
// - The open-drain port leaves reset high impedance and every other port as input.
// - The both-edge input requests an interrupt on every rising and falling edge.
// - The select-edge input requests an interrupt on the edge software picks.
// - Key inputs flag falling edges in a testable bit that raises no interrupt.
// - Segment pins turn into ports in groups of four, eight pins at most.
// - In PROM mode the open-drain port carries data bits 7 to 4.
// - In PROM mode the key port carries data bits 3 to 0.
// - Two third-port pins can output the expansion drive and sync clocks.
// - The bias output drives low with the split resistor and floats without it.
`timescale 1ns/1ns
`default_nettype none
module pfc_port_ctrl (
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    input  wire logic               i_ce,
    input  wire logic [pfc_pkg::AW-1:0] i_addr,
    input  wire logic [pfc_pkg::DW-1:0] i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic [pfc_pkg::DW-1:0]  o_rdata,
    output logic                    o_irq,
    input  wire logic [3:0]         i_input_port_a,
    output logic [3:0]              o_input_port_a,
    output logic [3:0]              o_input_port_a_oe,
    output logic [3:0]              o_input_port_a_pu,
    input  wire logic               i_select_edge_irq_in,
    input  wire logic [3:0]         i_prog_port_c,
    output logic [3:0]              o_prog_port_c,
    output logic [3:0]              o_prog_port_c_oe,
    output logic [3:0]              o_prog_port_c_pu,
    input  wire logic               i_expansion_drive_clock,
    input  wire logic               i_expansion_sync_clock,
    input  wire logic [3:0]         i_open_drain_port,
    output logic [3:0]              o_open_drain_port,
    output logic [3:0]              o_open_drain_port_oe,
    input  wire logic [3:0]         i_key_port,
    output logic [3:0]              o_key_port,
    output logic [3:0]              o_key_port_oe,
    output logic [3:0]              o_key_port_pu,
    input  wire logic [7:0]         i_shared_segment_pins,
    input  wire logic [7:0]         i_segment_drive,
    output logic [7:0]              o_shared_segment_pins,
    output logic [7:0]              o_shared_segment_pins_oe,
    output logic [7:0]              o_shared_segment_pins_pu,
    input  wire logic               i_prom_mode,
    input  wire logic               i_prom_drive,
    input  wire logic [7:0]         i_prom_rdata,
    output logic [7:0]              o_prom_data_lines,
    output logic [3:0]              o_prom_mode_select,
    output logic                    o_bias,
    output logic                    o_bias_oe
);
    import pfc_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [3:1] pa_out;
        logic [3:1] pa_dir;
        logic [3:1] pa_pu;
        logic [3:0] pc_out;
        logic [3:0] pc_dir;
        logic       pc_pu;
        logic [3:0] od_out;
        logic [3:0] pk_out;
        logic [3:0] pk_dir;
        logic       pk_pu;
        logic [1:0] seg_en;
        logic [7:0] seg_out;
        logic [7:0] seg_dir;
        logic [1:0] seg_pu;
        logic [3:0] cfg;
        logic [2:0] status;
        logic [1:0] mask;
        logic [7:0] rdata;
        logic       both_prev;
        logic       sel_prev;
        logic       sel_filt;
        logic [3:0] nf_cnt;
        logic [3:0] key_prev;
        logic [7:0] prom_data;
        logic [3:0] prom_mode;
    } pfc_state_s;

    pfc_state_s state;
    pfc_state_s next_state;
    logic       rst_meta_b;
    logic       rst_sync_b;
    logic       sel_in;
    logic       sel_rise;
    logic       sel_fall;
    logic [2:0] ev;
    logic [2:0] clr;
    logic       pc_unit_in;
    logic       pk_unit_in;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // ****************************************************************
    // Edge detection
    // ****************************************************************
    // Filtered or raw path
    assign sel_in   = state.cfg[CFG_NF_EN] ? state.sel_filt : i_select_edge_irq_in;
    assign sel_rise = sel_in & ~state.sel_prev;
    assign sel_fall = ~sel_in & state.sel_prev;

    always_comb begin
        ev = 3'h0;
        ev[ST_BOTH_EDGE] = i_input_port_a[0] ^ state.both_prev;
        ev[ST_SEL_EDGE]  = state.cfg[CFG_SEL_FALL] ? sel_fall : sel_rise;
        ev[ST_KEY]       = |(state.key_prev & ~i_key_port) & ~i_prom_mode;
    end

    assign clr = (i_wr && i_addr == R_STATUS) ? i_wdata[2:0] : 3'h0;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_state           = state;
        next_state.both_prev = i_input_port_a[0];
        next_state.sel_prev  = sel_in;
        next_state.key_prev  = i_key_port;
        // Set beats clear so a same-cycle event survives
        next_state.status    = (state.status & ~clr) | ev;

        // Input must hold steady to pass the filter
        if (i_select_edge_irq_in == state.sel_filt) begin
            next_state.nf_cnt = 4'h0;
        end else if (state.nf_cnt == NF_CYCLES - 4'h1) begin
            next_state.nf_cnt   = 4'h0;
            next_state.sel_filt = i_select_edge_irq_in;
        end else begin
            next_state.nf_cnt = state.nf_cnt + 4'h1;
        end

        // Upper data bits from open-drain pins
        // Lower data bits from key pins
        // Mode lines sampled from third port
        if (i_prom_mode) begin
            next_state.prom_data = {i_open_drain_port, i_key_port};
            next_state.prom_mode = i_prog_port_c;
        end

        if (i_wr) begin
            case (i_addr)
                R_PA_DATA:  next_state.pa_out  = i_wdata[3:1];
                R_PA_DIR:   next_state.pa_dir  = i_wdata[3:1];
                R_PA_PU:    next_state.pa_pu   = i_wdata[3:1];
                R_PC_DATA:  next_state.pc_out  = i_wdata[3:0];
                R_PC_DIR:   next_state.pc_dir  = i_wdata[3:0];
                R_PC_PU:    next_state.pc_pu   = i_wdata[0];
                R_OD_DATA:  next_state.od_out  = i_wdata[3:0];
                R_PK_DATA:  next_state.pk_out  = i_wdata[3:0];
                R_PK_DIR:   next_state.pk_dir  = i_wdata[3:0];
                R_PK_PU:    next_state.pk_pu   = i_wdata[0];
                R_SEG_EN:   next_state.seg_en  = i_wdata[1:0];
                R_SEG_DATA: next_state.seg_out = i_wdata;
                R_SEG_DIR:  next_state.seg_dir = i_wdata;
                R_SEG_PU:   next_state.seg_pu  = i_wdata[1:0];
                R_CFG:      next_state.cfg     = i_wdata[3:0];
                R_MASK:     next_state.mask    = i_wdata[1:0];
                default:    next_state.mask    = state.mask;
            endcase
        end

        next_state.rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                R_PA_DATA:  next_state.rdata = {4'h0, i_input_port_a};
                R_PA_DIR:   next_state.rdata = {4'h0, state.pa_dir, 1'b0};
                R_PA_PU:    next_state.rdata = {4'h0, state.pa_pu, 1'b0};
                R_PC_DATA:  next_state.rdata = {4'h0, i_prog_port_c};
                R_PC_DIR:   next_state.rdata = {4'h0, state.pc_dir};
                R_PC_PU:    next_state.rdata = {7'h00, state.pc_pu};
                R_OD_DATA:  next_state.rdata = {4'h0, i_open_drain_port};
                R_PK_DATA:  next_state.rdata = {4'h0, i_key_port};
                R_PK_DIR:   next_state.rdata = {4'h0, state.pk_dir};
                R_PK_PU:    next_state.rdata = {7'h00, state.pk_pu};
                R_SEG_EN:   next_state.rdata = {6'h00, state.seg_en};
                R_SEG_DATA: next_state.rdata = i_shared_segment_pins;
                R_SEG_DIR:  next_state.rdata = state.seg_dir;
                R_SEG_PU:   next_state.rdata = {6'h00, state.seg_pu};
                R_CFG:      next_state.rdata = {4'h0, state.cfg};
                R_STATUS:   next_state.rdata = {5'h00, state.status};
                R_MASK:     next_state.rdata = {6'h00, state.mask};
                default:    next_state.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge i_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state        <= '0;
            state.od_out <= OD_RESET;
            state.pc_dir <= DIR_RESET;
            state.pk_dir <= DIR_RESET;
            state.cfg    <= CFG_RESET;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    assign o_rdata = state.rdata;
    // Key flag kept out of the interrupt line on purpose
    assign o_irq   = |(state.status[1:0] & state.mask);

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    // Pull-up only when the nibble is all input
    assign pc_unit_in = (state.pc_dir == 4'h0) & ~state.cfg[CFG_EXP_CLK];
    assign pk_unit_in = (state.pk_dir == 4'h0);

    always_comb begin
        o_input_port_a    = {state.pa_out, 1'b0};
        o_input_port_a_oe = {state.pa_dir, 1'b0};
        o_input_port_a_pu = {state.pa_pu & ~state.pa_dir, 1'b0};

        o_prog_port_c     = state.pc_out;
        o_prog_port_c_oe  = state.pc_dir;
        o_prog_port_c_pu  = {4{state.pc_pu & pc_unit_in}};
        // Expansion clocks on bits 0 and 1
        if (state.cfg[CFG_EXP_CLK]) begin
            o_prog_port_c[1:0]    = {i_expansion_sync_clock, i_expansion_drive_clock};
            o_prog_port_c_oe[1:0] = 2'h3;
        end
        if (i_prom_mode) begin
            o_prog_port_c_oe = 4'h0;
            o_prog_port_c_pu = 4'h0;
        end

        // Drives only low; a one releases the pin
        o_open_drain_port    = 4'h0;
        o_open_drain_port_oe = ~state.od_out;

        o_key_port    = state.pk_out;
        o_key_port_oe = state.pk_dir;
        o_key_port_pu = {4{state.pk_pu & pk_unit_in}};

        if (i_prom_mode) begin
            o_open_drain_port_oe = i_prom_drive ? ~i_prom_rdata[7:4] : 4'h0;
            o_key_port    = i_prom_rdata[3:0];
            o_key_port_oe = {4{i_prom_drive}};
            o_key_port_pu = 4'h0;
        end

        // Two groups of four, LCD drive otherwise
        for (int g = 0; g < 2; g++) begin
            if (state.seg_en[g]) begin
                o_shared_segment_pins[g*4 +: 4]    = state.seg_out[g*4 +: 4];
                o_shared_segment_pins_oe[g*4 +: 4] = state.seg_dir[g*4 +: 4];
                o_shared_segment_pins_pu[g*4 +: 4] =
                    {4{state.seg_pu[g] & (state.seg_dir[g*4 +: 4] == 4'h0)}};
            end else begin
                o_shared_segment_pins[g*4 +: 4]    = i_segment_drive[g*4 +: 4];
                o_shared_segment_pins_oe[g*4 +: 4] = 4'hf;
                o_shared_segment_pins_pu[g*4 +: 4] = 4'h0;
            end
        end
    end

    assign o_prom_data_lines  = state.prom_data;
    assign o_prom_mode_select = state.prom_mode;

    // Low with split resistor, else float
    assign o_bias    = 1'b0;
    assign o_bias_oe = state.cfg[CFG_SPLIT_RES];
endmodule
`default_nettype wire

//--- pfc_port_ctrl_sva.sv
/*
 * Checker for the port and shared-pin control block, bound to its top.
 * Assumes one clock and the active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none
module pfc_port_ctrl_chk (
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    input wire logic       i_ce,
    input wire logic       i_rd,
    input wire logic       i_prom_mode,
    input wire logic       i_prom_drive,
    input wire logic [7:0] i_prom_rdata,
    input wire logic [3:0] i_open_drain_port,
    input wire logic [3:0] i_key_port,
    input wire logic [3:0] i_prog_port_c,
    input wire logic [7:0] o_rdata,
    input wire logic [3:0] o_input_port_a_oe,
    input wire logic [3:0] o_input_port_a_pu,
    input wire logic [3:0] o_prog_port_c_oe,
    input wire logic [3:0] o_prog_port_c_pu,
    input wire logic [3:0] o_open_drain_port,
    input wire logic [3:0] o_open_drain_port_oe,
    input wire logic [3:0] o_key_port,
    input wire logic [3:0] o_key_port_oe,
    input wire logic [3:0] o_key_port_pu,
    input wire logic [7:0] o_prom_data_lines,
    input wire logic [3:0] o_prom_mode_select,
    input wire logic       o_bias
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    // ****************************************************************
    // Pin and bus relations
    // ****************************************************************
    od_low_only_a: assert property (o_open_drain_port == 4'h0)
        else $error("open-drain port drove a high level");
    bias_low_a: assert property (o_bias == 1'b0)
        else $error("bias output drove high");
    pa_bit0_in_a: assert property (o_input_port_a_oe[0] == 1'b0)
        else $error("interrupt pin of port a driven");
    pa_pull_a: assert property ((o_input_port_a_pu & o_input_port_a_oe) == 4'h0)
        else $error("port a pull-up on an output bit");
    pc_pull_a: assert property (o_prog_port_c_pu != 4'h0 |-> o_prog_port_c_oe == 4'h0)
        else $error("port c pull-up with an output bit");
    key_pull_a: assert property (!i_prom_mode && o_key_port_pu != 4'h0 |-> o_key_port_oe == 4'h0)
        else $error("key port pull-up with an output bit");
    // A read leaves data for one cycle only
    rdata_idle_a: assert property (i_ce && !i_rd |=> o_rdata == 8'h00)
        else $error("read data outside the answer cycle");
    prom_data_a: assert property (i_ce && i_prom_mode |=>
        o_prom_data_lines == $past({i_open_drain_port, i_key_port}))
        else $error("prom data lines not sampled");
    mode_sel_a: assert property (i_ce && i_prom_mode |=>
        o_prom_mode_select == $past(i_prog_port_c))
        else $error("prom mode select not sampled");
    prom_pc_off_a: assert property (i_prom_mode && $past(i_prom_mode) |->
        o_prog_port_c_oe == 4'h0 && o_prog_port_c_pu == 4'h0)
        else $error("port c driven while the programmer owns it");
    prom_drive_a: assert property (i_prom_mode && i_prom_drive
        && $past(i_prom_mode && i_prom_drive) && $stable(i_prom_rdata)
        |-> o_key_port_oe == 4'hf && o_key_port == i_prom_rdata[3:0]
        && o_open_drain_port_oe == ~i_prom_rdata[7:4])
        else $error("prom verify data not on the pins");
endmodule
bind pfc_port_ctrl pfc_port_ctrl_chk i_chk (.i_clk, .i_rst_b, .i_ce, .i_rd, .i_prom_mode,
    .i_prom_drive, .i_prom_rdata, .i_open_drain_port, .i_key_port, .i_prog_port_c,
    .o_rdata, .o_input_port_a_oe, .o_input_port_a_pu, .o_prog_port_c_oe, .o_prog_port_c_pu,
    .o_open_drain_port, .o_open_drain_port_oe, .o_key_port, .o_key_port_oe, .o_key_port_pu,
    .o_prom_data_lines, .o_prom_mode_select, .o_bias);
`default_nettype wire

//--- pfc_board.sv
/*
 * Board model: pin wiring, pull-ups, keys and the PROM programmer.
 * Assumes pins packed as {seg, key, open drain, port c, port a}.
 */
`timescale 1ns/1ns
`default_nettype none
module pfc_board (
    input  wire logic        i_clk,
    input  wire logic [23:0] i_out,
    input  wire logic [23:0] i_oe,
    input  wire logic [23:0] i_pu,
    input  wire logic [23:0] i_drv_en,
    input  wire logic [23:0] i_drv,
    output logic      [23:0] o_pin
);
    // ****************************************************************
    // Pin resolution
    // ****************************************************************
    logic [23:0] last = 24'h000000;
    // programmer drives
    // Undriven lines without a pull-up flip so a stale level never passes as data
    assign o_pin = (i_oe & i_out) | (~i_oe & i_drv_en & i_drv)
                 | (~i_oe & ~i_drv_en & (i_pu | ~last));
    always @(posedge i_clk) last <= o_pin;
endmodule
`default_nettype wire

//--- tb_top.sv
/*
 * Self-checking bench for the port and shared-pin control block.
 * Assumes the board model and checker come first.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import pfc_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        i_ce = 1'b1;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        sel = 1'b0;
    logic        pm = 1'b0;
    logic        pd = 1'b0;
    logic [1:0]  xclk = 2'b00;
    logic [4:0]  i_addr = 5'h00;
    logic [7:0]  i_wdata = 8'h00;
    logic [7:0]  seg_drv = 8'h00;
    logic [7:0]  prd = 8'h00;
    logic [23:0] drv_en = 24'h00f001;
    logic [23:0] drv = 24'h00f000;
    logic [23:0] pin;
    logic [7:0]  rdata, pdl, s_o, s_oe, s_pu, u, v;
    logic [3:0]  a_o, a_oe, a_pu, c_o, c_oe, c_pu, od_o, od_oe, k_o, k_oe, k_pu, pms, dir;
    logic        irq, bias, bias_oe;
    int          fails = 0;
    int          checks_done = 0;
    always #25 i_clk = ~i_clk;
    pfc_port_ctrl i_dut (.i_clk, .i_rst_b, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata(rdata), .o_irq(irq), .i_input_port_a(pin[3:0]), .o_input_port_a(a_o),
        .o_input_port_a_oe(a_oe), .o_input_port_a_pu(a_pu), .i_select_edge_irq_in(sel),
        .i_prog_port_c(pin[7:4]), .o_prog_port_c(c_o), .o_prog_port_c_oe(c_oe),
        .o_prog_port_c_pu(c_pu), .i_expansion_drive_clock(xclk[0]),
        .i_expansion_sync_clock(xclk[1]), .i_open_drain_port(pin[11:8]),
        .o_open_drain_port(od_o), .o_open_drain_port_oe(od_oe), .i_key_port(pin[15:12]),
        .o_key_port(k_o), .o_key_port_oe(k_oe), .o_key_port_pu(k_pu),
        .i_shared_segment_pins(pin[23:16]), .i_segment_drive(seg_drv),
        .o_shared_segment_pins(s_o), .o_shared_segment_pins_oe(s_oe),
        .o_shared_segment_pins_pu(s_pu), .i_prom_mode(pm), .i_prom_drive(pd),
        .i_prom_rdata(prd), .o_prom_data_lines(pdl), .o_prom_mode_select(pms),
        .o_bias(bias), .o_bias_oe(bias_oe));
    // Open-drain pins carry a board pull-up
    pfc_board i_board (.i_clk, .i_out({s_o, k_o, od_o, c_o, a_o}),
        .i_oe({s_oe, k_oe, od_oe, c_oe, a_oe}), .i_pu({s_pu, k_pu, 4'hf, c_pu, a_pu}),
        .i_drv_en(drv_en), .i_drv(drv), .o_pin(pin));
    // ****************************************************************
    // Expectations, bus cycles and checks
    // ****************************************************************
    function automatic logic [3:0] f_nib_pu(input logic [3:0] d);
        return (d == 4'h0) ? 4'hf : 4'h0;
    endfunction
    function automatic logic [7:0] f_seg(input logic [1:0] en, input logic [7:0] a, b);
        return {en[1] ? a[7:4] : b[7:4], en[0] ? a[3:0] : b[3:0]};
    endfunction
    task automatic chk(input logic [7:0] s, e, input string n);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e, input string n);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        chk(rdata, e, n);
    endtask
    // Bounded wait; a timeout fails and ends the run
    task automatic wait_irq(input logic e);
        for (int n = 0; n < 20 && irq !== e; n++) @(negedge i_clk);
        chk({7'h0, irq}, {7'h0, e}, "irq");
        if (irq !== e) finish_test();
    endtask
    initial begin
        void'($urandom(10783));
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        chk({od_oe, c_oe}, 8'h00, "reset_oe");
        chk({k_oe, a_oe}, 8'h00, "reset_dir");
        wr(5'h1f, 8'hff);
        rd(5'h1f, 8'h00, "unmapped");
        rd(R_CFG, 8'h00, "cfg_reset");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            dir = (i < 2) ? 4'h0 : 4'($urandom);
            wr(R_PC_DIR, {4'h0, dir});
            wr(R_PC_DATA, v);
            wr(R_OD_DATA, v);
            wr(R_PC_PU, 8'h01);
            wr(R_PK_DIR, {4'h0, dir});
            wr(R_PK_PU, 8'h01);
            wr(R_PA_DIR, {4'h0, dir});
            wr(R_PA_PU, 8'h0e);
            @(negedge i_clk);
            chk({od_oe, c_oe}, {~v[3:0], dir}, "pc_oe");
            chk(c_o & dir, v[3:0] & dir, "pc_out");
            chk(c_pu, f_nib_pu(dir), "pc_pu");
            chk({k_oe, k_pu}, {dir, f_nib_pu(dir)}, "pk_dir_pu");
            chk({a_oe, a_pu}, {dir & 4'he, ~dir & 4'he}, "pa_dir_pu");
        end
        wr(R_PC_DIR, 8'h00);
        wr(R_PK_DIR, 8'h00);
        @(posedge i_clk) i_ce <= 1'b0;
        wr(R_PC_DIR, 8'h0f);
        i_ce <= 1'b1;
        rd(R_PC_DIR, 8'h00, "ce_hold");
        $display("test direction done");
        wr(R_MASK, 8'h03);
        wr(R_STATUS, 8'h07);
        for (int e = 0; e < 2; e++) begin
            @(posedge i_clk) drv[0] <= ~drv[0];
            wait_irq(1'b1);
            rd(R_STATUS, 8'h01, "both_edge");
            wr(R_STATUS, 8'h01);
            wait_irq(1'b0);
        end
        wr(R_MASK, 8'h02);
        @(posedge i_clk) drv[0] <= ~drv[0];
        repeat (4) @(negedge i_clk);
        chk({7'h0, irq}, 8'h00, "masked");
        rd(R_STATUS, 8'h01, "masked_st");
        wr(R_STATUS, 8'h01);
        wr(R_MASK, 8'h03);
        $display("test both edge done");
        for (int m = 0; m < 2; m++) begin
            wr(R_CFG, 8'(m));
            for (int e = 0; e < 2; e++) begin
                @(posedge i_clk) sel <= ~sel;
                repeat (4) @(posedge i_clk);
                rd(R_STATUS, {6'h0, sel != m[0], 1'b0}, "sel_edge");
                wr(R_STATUS, 8'h02);
            end
        end
        wr(R_CFG, 8'h02);
        @(posedge i_clk) sel <= 1'b1;
        @(posedge i_clk);
        rd(R_STATUS, 8'h00, "nf_delay");
        repeat (8) @(posedge i_clk);
        rd(R_STATUS, 8'h02, "nf_pass");
        wr(R_STATUS, 8'h02);
        @(posedge i_clk) sel <= 1'b0;
        repeat (8) @(posedge i_clk);
        sel <= 1'b1;
        repeat (2) @(posedge i_clk);
        sel <= 1'b0;
        repeat (10) @(posedge i_clk);
        rd(R_STATUS, 8'h00, "nf_glitch");
        $display("test select edge done");
        wr(R_MASK, 8'hff);
        rd(R_MASK, 8'h03, "mask_bits");
        @(posedge i_clk) drv[12] <= 1'b0;
        repeat (4) @(negedge i_clk);
        chk({7'h0, irq}, 8'h00, "key_noirq");
        rd(R_STATUS, 8'h04, "key_fall");
        wr(R_STATUS, 8'h04);
        @(posedge i_clk) drv[12] <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd(R_STATUS, 8'h00, "key_rise");
        $display("test key done");
        for (int g = 1; g < 4; g++) begin
            u = 8'($urandom);
            v = 8'($urandom);
            wr(R_SEG_EN, 8'(g));
            seg_drv <= 8'($urandom);
            wr(R_SEG_DIR, u);
            wr(R_SEG_DATA, v);
            @(negedge i_clk);
            chk(s_oe, f_seg(g[1:0], u, 8'hff), "seg_oe");
            chk(s_o & s_oe, f_seg(g[1:0], v, seg_drv) & s_oe, "seg_out");
        end
        $display("test segment done");
        wr(R_PC_DIR, 8'h0f);
        wr(R_PC_DATA, 8'h00);
        wr(R_CFG, 8'h04);
        for (int i = 0; i < 4; i++) begin
            xclk <= (i == 0) ? 2'b11 : 2'($urandom);
            @(negedge i_clk);
            chk(c_o[1:0], xclk, "exp_clk");
            @(posedge i_clk);
        end
        wr(R_CFG, 8'h08);
        @(negedge i_clk);
        chk({c_o[1:0], bias_oe, bias}, 8'h02, "bias_split");
        wr(R_CFG, 8'h00);
        @(negedge i_clk);
        chk({bias_oe, bias}, 8'h00, "bias_none");
        $display("test alternate done");
        v = 8'($urandom);
        u = 8'($urandom);
        @(posedge i_clk);
        pm <= 1'b1;
        drv_en <= 24'h00fff1;
        drv <= {8'h00, v[3:0], v[7:4], u[3:0], 3'h0, drv[0]};
        repeat (3) @(negedge i_clk);
        chk(pdl, v, "prom_in");
        chk(pms, u[3:0], "prom_mode");
        @(posedge i_clk);
        prd <= 8'($urandom);
        pd <= 1'b1;
        drv_en <= 24'h0000f1;
        repeat (3) @(negedge i_clk);
        chk(pin[15:8], {prd[3:0], prd[7:4]}, "prom_out");
        $display("test prom done");
        finish_test();
    end
endmodule
`default_nettype wire
